// ### core/rpe_core.sv
// Summary of operation
// [RULE_01] Each channel delivers a signed 24-bit sample per strobe at the ADC rate.
// [RULE_02] Rms of both currents and voltage computed together, refreshed per sample; the code roots them one after another (ia, ib, v) over 72 cycles.
// [RULE_03] Rms is the square root of the low-pass filtered squared samples.
// [RULE_04] Current rms results readable at 0x21A/0x21B and aliases 0x31A/0x31B.
// [RULE_05] Voltage rms result readable at 0x21C and alias 0x31C.
// [RULE_06] Full-scale sine reads about 9032007 in every rms register.
// [RULE_07] Host should read rms values in step with voltage zero crossings.
// [RULE_08] Active power is the low-pass filtered product of current and voltage.
// [RULE_09] Channel A and B power computed in parallel, at 0x212/0x213 plus aliases.
// [RULE_10] Full-scale in-phase inputs give about 4862401 in each power register.
// [RULE_11] Power keeps in-band harmonics and refreshes at every sample.
// [RULE_12] Power is signed; sign flags of both channels read in 0x201.
// [RULE_13] Power adds into a 48-bit accumulator per sample; threshold emits pulse.
// [RULE_14] Each pulse steps the 24-bit energy register at 0x21E or 0x21F.
// [RULE_15] Both stages are signed; negative power counts the energy down.
// [RULE_16] Energy wraps 0x7FFFFF to 0x800000 upward and back downward.
// [RULE_17] Reading energy clears it unless bit 6 of 0x004 is cleared.
// [RULE_18] Half-full and overflow events per channel raise irq when enabled.
// [RULE_19] A pulse removes the threshold and keeps the remainder, either sign.
// [RULE_20] Half full is magnitude 0x400000; flags stay latched until cleared.
`default_nettype none
module rpe_core #(
  parameter int                 LPF_SHIFT        = rpe_pkg::LPF_SHIFT,
  parameter logic signed [47:0] ENERGY_THRESHOLD = rpe_pkg::ENERGY_THRESHOLD
) (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_in,
  input  wire logic               clk_en_in,
  input  wire logic               sample_valid_in,
  input  wire logic signed [23:0] ia_sample_in,
  input  wire logic signed [23:0] ib_sample_in,
  input  wire logic signed [23:0] v_sample_in,
  input  wire logic        [9:0]  reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic        [23:0] reg_wdata_in,
  input  wire logic        [3:0]  flag_clear_in,
  output logic             [23:0] reg_rdata_out,
  output logic                    reg_rvalid_out,
  output logic             [3:0]  energy_flags_out,
  output logic                    irq_out
);
  // ==========================================================
  // functions
  function automatic logic signed [47:0] iir_step(input logic signed [47:0] acc,
                                                   input logic signed [47:0] x);
    logic signed [48:0] diff;
    diff = 49'(x) - 49'(acc);
    iir_step = acc + 48'(diff >>> LPF_SHIFT);
  endfunction

  function automatic logic [23:0] rms_scale(input logic [23:0] root);
    logic [40:0] s;
    s = (41'(root) * 41'(rpe_pkg::RMS_GAIN)) >> rpe_pkg::RMS_GAIN_SHIFT;
    rms_scale = (|s[40:24]) ? 24'hffffff : s[23:0];
  endfunction

  function automatic logic [23:0] pwr_scale(input logic signed [47:0] avg);
    logic signed [65:0] p;
    p = (66'(avg) * $signed(66'(rpe_pkg::PWR_GAIN))) >>> rpe_pkg::PWR_SHIFT;
    if (p > 66'sd8388607) pwr_scale = rpe_pkg::ENERGY_MAX;
    else if (p < -66'sd8388608) pwr_scale = rpe_pkg::ENERGY_MIN;
    else pwr_scale = p[23:0];
  endfunction

  function automatic logic reg_hit(input logic [9:0] addr, input logic [9:0] base);
    reg_hit = ((addr & ~rpe_pkg::ALIAS_MASK) == base);
  endfunction

  // ==========================================================
  // mean square and power filters
  logic signed [23:0] samp [3];
  logic signed [47:0] sq   [3];
  logic signed [47:0] prod [2];
  logic signed [47:0] ms_q [3];
  logic signed [47:0] pavg_q [2];
  logic signed [23:0] watt_q [2];
  logic               valid_d1_q;
  logic               valid_d2_q;

  assign samp[0] = ia_sample_in; // [RULE_01]
  assign samp[1] = ib_sample_in;
  assign samp[2] = v_sample_in;

  for (genvar g = 0; g < 3; g++) begin : g_sq
    assign sq[g] = samp[g] * samp[g]; // [RULE_03]
  end
  for (genvar g = 0; g < 2; g++) begin : g_prod
    assign prod[g] = samp[g] * samp[2]; // [RULE_08]
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      valid_d1_q <= 1'b0;
      valid_d2_q <= 1'b0;
      for (int i = 0; i < 3; i++) ms_q[i] <= 48'sh0;
      for (int i = 0; i < 2; i++) pavg_q[i] <= 48'sh0;
      for (int i = 0; i < 2; i++) watt_q[i] <= 24'sh0;
    end else if (clk_en_in) begin
      valid_d1_q <= sample_valid_in;
      valid_d2_q <= valid_d1_q;
      if (sample_valid_in) begin
        for (int i = 0; i < 3; i++) ms_q[i] <= iir_step(ms_q[i], sq[i]); // [RULE_02] [RULE_03]
        for (int i = 0; i < 2; i++) pavg_q[i] <= iir_step(pavg_q[i], prod[i]); // [RULE_08] [RULE_09]
      end
      if (valid_d1_q) begin
        for (int i = 0; i < 2; i++) watt_q[i] <= pwr_scale(pavg_q[i]); // [RULE_10] [RULE_11] [RULE_12]
      end
    end
  end

  // ==========================================================
  // shared bit-serial square root, one channel after another
  rpe_pkg::rpe_sqrt_state_e sq_state_q;
  logic [1:0]         sq_ch_q;
  logic [4:0]         sq_bit_q;
  logic [23:0]        root_q;
  logic [23:0]        rms_q [3];
  logic [47:0]        sq_x;
  logic [23:0]        trial;
  logic [47:0]        trial_sq;
  logic [23:0]        root_d;
  logic               rms_wr;

  assign sq_x     = ms_q[sq_ch_q];
  assign trial    = root_q | (24'h000001 << sq_bit_q);
  assign trial_sq = trial * trial;
  assign root_d   = (trial_sq <= sq_x) ? trial : root_q; // [RULE_03]
  assign rms_wr   = clk_en_in && (sq_state_q == rpe_pkg::RPE_SQ_RUN) && (sq_bit_q == 5'd0);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sq_state_q <= rpe_pkg::RPE_SQ_IDLE;
      sq_ch_q    <= 2'd0;
      sq_bit_q   <= 5'd23;
      root_q     <= 24'h0;
      for (int i = 0; i < 3; i++) rms_q[i] <= 24'h0;
    end else if (clk_en_in) begin
      unique case (sq_state_q)
        rpe_pkg::RPE_SQ_IDLE: begin
          if (valid_d1_q) begin
            sq_state_q <= rpe_pkg::RPE_SQ_RUN;
            sq_ch_q    <= 2'd0;
            sq_bit_q   <= 5'd23;
            root_q     <= 24'h0;
          end
        end
        rpe_pkg::RPE_SQ_RUN: begin
          if (sq_bit_q == 5'd0) begin
            rms_q[sq_ch_q] <= rms_scale(root_d); // [RULE_02] [RULE_06]
            root_q         <= 24'h0;
            sq_bit_q       <= 5'd23;
            sq_ch_q        <= (sq_ch_q == 2'd2) ? 2'd0 : sq_ch_q + 2'd1;
            if (sq_ch_q == 2'd2) sq_state_q <= rpe_pkg::RPE_SQ_IDLE;
          end else begin
            root_q   <= root_d;
            sq_bit_q <= sq_bit_q - 5'd1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // two-stage energy accumulation
  logic        [7:0]  lcyc_q;
  logic        [23:0] accumulation_mode_cfg_q;
  logic        [23:0] irqen_q [2];
  logic signed [47:0] acc_q [2];
  logic        [23:0] energy_q [2];
  logic        [3:0]  flags_q;
  logic               clr_on_read;
  logic               pulse_up [2];
  logic               pulse_dn [2];
  logic               rd_clear [2];
  logic        [23:0] e_base [2];
  logic        [23:0] e_next [2];
  logic signed [47:0] acc_next [2];
  logic        [3:0]  events;
  logic        [3:0]  irq_en_bits;
  logic        [9:0]  energy_addr [2];

  assign clr_on_read    = lcyc_q[rpe_pkg::CLR_ON_READ_BIT];
  assign energy_addr[0] = rpe_pkg::ADDR_ENERGY_A;
  assign energy_addr[1] = rpe_pkg::ADDR_ENERGY_B;

  for (genvar g = 0; g < 2; g++) begin : g_en
    assign pulse_up[g] = clk_en_in && !valid_d2_q && (acc_q[g] >= ENERGY_THRESHOLD); // [RULE_13]
    assign pulse_dn[g] = clk_en_in && !valid_d2_q && (acc_q[g] <= -ENERGY_THRESHOLD); // [RULE_19]
    assign acc_next[g] = valid_d2_q  ? acc_q[g] + 48'(watt_q[g]) : // [RULE_13] [RULE_15]
                         pulse_up[g] ? acc_q[g] - ENERGY_THRESHOLD : // [RULE_19]
                         pulse_dn[g] ? acc_q[g] + ENERGY_THRESHOLD : acc_q[g];
    assign rd_clear[g] = clk_en_in && reg_rd_in && clr_on_read && reg_hit(reg_addr_in, energy_addr[g]); // [RULE_17]
    assign e_base[g]   = rd_clear[g] ? 24'h0 : energy_q[g];
    // wrap at the extremes falls out of 24-bit two's complement
    assign e_next[g]   = pulse_up[g] ? e_base[g] + 24'h1 : // [RULE_14] [RULE_16]
                         pulse_dn[g] ? e_base[g] - 24'h1 : e_base[g]; // [RULE_15]
    assign events[2*g]   = (pulse_up[g] && e_base[g] == rpe_pkg::HALF_UP_FROM) ||
                           (pulse_dn[g] && e_base[g] == rpe_pkg::HALF_DN_FROM); // [RULE_20]
    assign events[2*g+1] = (pulse_up[g] && e_base[g] == rpe_pkg::ENERGY_MAX) ||
                           (pulse_dn[g] && e_base[g] == rpe_pkg::ENERGY_MIN); // [RULE_18]
    assign irq_en_bits[2*g]   = irqen_q[g][rpe_pkg::HALF_FULL_EN_BIT];
    assign irq_en_bits[2*g+1] = irqen_q[g][rpe_pkg::OVERFLOW_EN_BIT];
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2; i++) acc_q[i] <= 48'sh0;
      for (int i = 0; i < 2; i++) energy_q[i] <= 24'h0;
      flags_q <= 4'h0;
    end else if (clk_en_in) begin
      for (int i = 0; i < 2; i++) acc_q[i] <= acc_next[i];
      for (int i = 0; i < 2; i++) energy_q[i] <= e_next[i];
      // a new event beats a clear in the same cycle
      flags_q <= (flags_q & ~flag_clear_in) | events; // [RULE_20]
    end
  end

  assign irq_out          = |(flags_q & irq_en_bits); // [RULE_18]
  assign energy_flags_out = flags_q;

  // ==========================================================
  // register port
  logic        wr_en;
  logic        rd_en;
  logic [23:0] accumulation_mode_cfg_rd;
  logic [23:0] rdata_d;
  logic        lcyc_hit;

  assign wr_en    = clk_en_in && reg_wr_in;
  assign rd_en    = clk_en_in && reg_rd_in;
  assign lcyc_hit = (reg_addr_in == rpe_pkg::ADDR_LCYC);

  always_comb begin
    accumulation_mode_cfg_rd = accumulation_mode_cfg_q;
    accumulation_mode_cfg_rd[rpe_pkg::SIGN_A_BIT] = watt_q[0][23]; // [RULE_12]
    accumulation_mode_cfg_rd[rpe_pkg::SIGN_B_BIT] = watt_q[1][23];
  end

  assign rdata_d =
    lcyc_hit                                   ? {16'h0, lcyc_q} :
    reg_hit(reg_addr_in, rpe_pkg::ADDR_ACCUMULATION_MODE_CFG)  ? accumulation_mode_cfg_rd :
    reg_hit(reg_addr_in, rpe_pkg::ADDR_WATT_A)   ? watt_q[0] : // [RULE_09]
    reg_hit(reg_addr_in, rpe_pkg::ADDR_WATT_B)   ? watt_q[1] :
    reg_hit(reg_addr_in, rpe_pkg::ADDR_IRMS_A)   ? rms_q[0] : // [RULE_04]
    reg_hit(reg_addr_in, rpe_pkg::ADDR_IRMS_B)   ? rms_q[1] :
    reg_hit(reg_addr_in, rpe_pkg::ADDR_VOLTAGE_RMS_VALUE)     ? rms_q[2] : // [RULE_05]
    reg_hit(reg_addr_in, rpe_pkg::ADDR_ENERGY_A) ? energy_q[0] :
    reg_hit(reg_addr_in, rpe_pkg::ADDR_ENERGY_B) ? energy_q[1] :
    reg_hit(reg_addr_in, rpe_pkg::ADDR_IRQEN_A)  ? irqen_q[0] :
    reg_hit(reg_addr_in, rpe_pkg::ADDR_IRQEN_B)  ? irqen_q[1] : 24'h0;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lcyc_q         <= rpe_pkg::LCYC_RESET;
      accumulation_mode_cfg_q      <= rpe_pkg::ACCUMULATION_MODE_CFG_RESET;
      irqen_q[0]     <= rpe_pkg::IRQEN_RESET;
      irqen_q[1]     <= rpe_pkg::IRQEN_RESET;
      reg_rdata_out  <= 24'h0;
      reg_rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      reg_rvalid_out <= reg_rd_in;
      if (rd_en) reg_rdata_out <= rdata_d;
      if (wr_en && lcyc_hit) lcyc_q <= reg_wdata_in[7:0]; // [RULE_17]
      if (wr_en && reg_hit(reg_addr_in, rpe_pkg::ADDR_ACCUMULATION_MODE_CFG)) accumulation_mode_cfg_q <= reg_wdata_in;
      if (wr_en && reg_hit(reg_addr_in, rpe_pkg::ADDR_IRQEN_A)) irqen_q[0] <= reg_wdata_in; // [RULE_18]
      if (wr_en && reg_hit(reg_addr_in, rpe_pkg::ADDR_IRQEN_B)) irqen_q[1] <= reg_wdata_in;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || !clk_en_in);

  sequence s_sample_taken;
    valid_d1_q && sq_state_q == rpe_pkg::RPE_SQ_IDLE;
  endsequence
  sequence s_voltage_rms_written;
    rms_wr && sq_ch_q == 2'd2;
  endsequence

  AST_RMS_REFRESH: assert property (s_sample_taken |-> ##72 s_voltage_rms_written) // [RULE_02]
    else $error("voltage rms not refreshed 72 cycles after sample");
  AST_SQRT_EXACT: assert property (rms_wr |-> (50'(root_d) * 50'(root_d) <= 50'(sq_x)) && // [RULE_03]
                                   ((50'(root_d) + 50'd1) * (50'(root_d) + 50'd1) > 50'(sq_x)))
    else $error("square root result is not the floor root");
  AST_IRMS_ALIAS: assert property (reg_rd_in && reg_addr_in == 10'h31a |=> // [RULE_04]
                                   reg_rvalid_out && reg_rdata_out == $past(rms_q[0]))
    else $error("alias read of current rms wrong");
  AST_VOLTAGE_RMS_VALUE_READ: assert property (reg_rd_in && reg_addr_in == rpe_pkg::ADDR_VOLTAGE_RMS_VALUE |=> // [RULE_05]
                                  reg_rdata_out == $past(rms_q[2]))
    else $error("voltage rms read wrong");
  AST_SIGN_READ: assert property (reg_rd_in && reg_addr_in == rpe_pkg::ADDR_ACCUMULATION_MODE_CFG |=> // [RULE_12]
                                  reg_rdata_out[rpe_pkg::SIGN_B_BIT] == $past(watt_q[1][23]))
    else $error("power sign flag does not follow power");
  AST_ACC_ADD: assert property (valid_d2_q |=> acc_q[0] == $past(acc_q[0]) + 48'($past(watt_q[0]))) // [RULE_13]
    else $error("power not added to first stage");
  AST_PULSE_REMAINDER: assert property (pulse_dn[1] |=> acc_q[1] == $past(acc_q[1]) + ENERGY_THRESHOLD) // [RULE_19]
    else $error("negative pulse did not restore remainder");
  AST_WRAP_UP: assert property (pulse_up[0] && !rd_clear[0] && energy_q[0] == rpe_pkg::ENERGY_MAX |=> // [RULE_16]
                                energy_q[0] == rpe_pkg::ENERGY_MIN && flags_q[1])
    else $error("energy did not wrap upward");
  AST_WRAP_DN: assert property (pulse_dn[1] && !rd_clear[1] && energy_q[1] == rpe_pkg::ENERGY_MIN |=> // [RULE_16]
                                energy_q[1] == rpe_pkg::ENERGY_MAX && flags_q[3])
    else $error("energy did not wrap downward");
  AST_CLEAR_ON_READ: assert property (rd_clear[0] && !pulse_up[0] && !pulse_dn[0] |=> energy_q[0] == 24'h0) // [RULE_17]
    else $error("energy not cleared by read");
  AST_FLAG_STICKY: assert property (flags_q[0] && !flag_clear_in[0] |=> flags_q[0]) // [RULE_20]
    else $error("half-full flag dropped without clear");
  AST_IRQ_ENABLED: assert property (events[1] && irq_en_bits[1] |=> irq_out) // [RULE_18]
    else $error("enabled overflow did not raise irq");
endmodule : rpe_core
`default_nettype wire

// ### core/rpe_pkg.sv
`default_nettype none
package rpe_pkg;
  localparam int          ADDR_W           = 10;
  localparam int          DATA_W           = 24;
  localparam logic [9:0]  ADDR_LCYC        = 10'h004;
  localparam logic [9:0]  ADDR_ACCUMULATION_MODE_CFG     = 10'h201;
  localparam logic [9:0]  ADDR_WATT_A      = 10'h212;
  localparam logic [9:0]  ADDR_WATT_B      = 10'h213;
  localparam logic [9:0]  ADDR_IRMS_A      = 10'h21a;
  localparam logic [9:0]  ADDR_IRMS_B      = 10'h21b;
  localparam logic [9:0]  ADDR_VOLTAGE_RMS_VALUE        = 10'h21c;
  localparam logic [9:0]  ADDR_ENERGY_A    = 10'h21e;
  localparam logic [9:0]  ADDR_ENERGY_B    = 10'h21f;
  localparam logic [9:0]  ADDR_IRQEN_A     = 10'h22c;
  localparam logic [9:0]  ADDR_IRQEN_B     = 10'h22f;
  localparam logic [9:0]  ALIAS_MASK       = 10'h100;
  localparam int          CLR_ON_READ_BIT  = 6;
  localparam logic [7:0]  LCYC_RESET       = 8'h40;
  localparam int          SIGN_A_BIT       = 10;
  localparam int          SIGN_B_BIT       = 11;
  localparam logic [23:0] ACCUMULATION_MODE_CFG_RESET    = 24'h000000;
  localparam logic [23:0] IRQEN_RESET      = 24'h000000;
  localparam int          HALF_FULL_EN_BIT = 0;
  localparam int          OVERFLOW_EN_BIT  = 1;
  localparam logic [23:0] ENERGY_MAX       = 24'h7fffff;
  localparam logic [23:0] ENERGY_MIN       = 24'h800000;
  localparam logic [23:0] HALF_UP_FROM     = 24'h3fffff;
  localparam logic [23:0] HALF_DN_FROM     = 24'hc00001;
  localparam logic [16:0] RMS_GAIN         = 17'h1f712;
  localparam int          RMS_GAIN_SHIFT   = 16;
  localparam logic [15:0] PWR_GAIN         = 16'hf72c;
  localparam int          PWR_SHIFT        = 38;
  localparam int          LPF_SHIFT        = 8;
  localparam logic [47:0] ENERGY_THRESHOLD = 48'h000000028a6c;
  localparam int          SQRT_CYCLES      = 72;
  typedef enum logic [0:0] {
    RPE_SQ_IDLE = 1'b0,
    RPE_SQ_RUN  = 1'b1
  } rpe_sqrt_state_e;
endpackage : rpe_pkg
`default_nettype wire

// ### bench/rpe_adc_model.sv
`default_nettype none
// ==========================================================
// decimated sample stream source for the three channels
// ==========================================================
module rpe_adc_model #(
  parameter int SPACING = 100
) (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_in,
  input  wire logic               run_in,
  input  wire logic signed [23:0] ia_level_in,
  input  wire logic signed [23:0] ib_level_in,
  input  wire logic signed [23:0] v_level_in,
  output logic                    sample_valid_out,
  output logic signed      [23:0] ia_out,
  output logic signed      [23:0] ib_out,
  output logic signed      [23:0] v_out
);
  timeunit 1ns;
  timeprecision 1ns;

  int   gap_q;
  logic flip_q;

  initial begin
    gap_q = 0;
    flip_q = 1'b0;
    sample_valid_out = 1'b0;
    ia_out = 24'h000000;
    ib_out = 24'h000000;
    v_out = 24'h000000;
  end

  // samples hold only in the strobe cycle; lines toggle otherwise
  always @(posedge sys_clk_in) begin
    sample_valid_out <= 1'b0;
    ia_out <= ~ia_out;
    ib_out <= ~ib_out;
    v_out <= ~v_out;
    if (rst_in || !run_in) begin
      gap_q <= 0;
    end else if (gap_q == 0) begin
      gap_q <= SPACING - 1;
      flip_q <= ~flip_q;
      sample_valid_out <= 1'b1;
      ia_out <= flip_q ? -ia_level_in : ia_level_in;
      ib_out <= flip_q ? -ib_level_in : ib_level_in;
      v_out <= flip_q ? -v_level_in : v_level_in;
    end else begin
      gap_q <= gap_q - 1;
    end
  end
endmodule // rpe_adc_model
`default_nettype wire

// ### bench/rpe_core_test.sv
`default_nettype none
module rpe_core_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int SPACING = 100;

  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic               clk_en = 1'b1;
  logic               valid;
  logic signed [23:0] ia;
  logic signed [23:0] ib;
  logic signed [23:0] v;
  logic        [9:0]  addr = 10'h000;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic        [23:0] wdata = 24'h000000;
  logic        [3:0]  flag_clear = 4'h0;
  logic        [23:0] rdata;
  logic               rvalid;
  logic        [3:0]  flags;
  logic               irq;
  logic               run = 1'b0;
  logic signed [23:0] ia_lvl = 24'sh020000;
  logic signed [23:0] ib_lvl = -24'sh020000;
  logic signed [23:0] v_lvl = 24'sh020000;
  int                 err_count = 0;
  int                 checks_done = 0;
  logic        [23:0] d0, d1, d2;
  logic               seen;

  always #50 sys_clk = ~sys_clk;

  rpe_core #(.LPF_SHIFT(2), .ENERGY_THRESHOLD(48'sd1000)) u_rpe_core (
    .sys_clk_in(sys_clk), .rst_in(rst), .clk_en_in(clk_en), .sample_valid_in(valid),
    .ia_sample_in(ia), .ib_sample_in(ib), .v_sample_in(v), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .flag_clear_in(flag_clear),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .energy_flags_out(flags), .irq_out(irq));

  rpe_adc_model #(.SPACING(SPACING)) u_rpe_adc_model (
    .sys_clk_in(sys_clk), .rst_in(rst), .run_in(run), .ia_level_in(ia_lvl),
    .ib_level_in(ib_lvl), .v_level_in(v_lvl), .sample_valid_out(valid),
    .ia_out(ia), .ib_out(ib), .v_out(v));

  // ==========================================================
  // compare and access tasks
  // ==========================================================
  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [9:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [9:0] a, output logic [23:0] d);
    int n;
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      if (rvalid === 1'b1) break;
    end
    if (n == 4) check_flag(1'b0, 1'b1);
    d = rdata;
  endtask

  task automatic run_samples(input int n);
    @(posedge sys_clk);
    run <= 1'b1;
    repeat (n * SPACING) @(posedge sys_clk);
    run <= 1'b0;
    // let pending energy pulses and the root pass finish
    repeat (200) @(posedge sys_clk);
  endtask

  task automatic give_verdict;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog
  // ==========================================================
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    give_verdict;
  end

  // ==========================================================
  // test sequence
  // ==========================================================
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(rpe_pkg::ADDR_LCYC, d0);     check_val(d0, 24'h000040);
    reg_read(rpe_pkg::ADDR_ACCUMULATION_MODE_CFG, d0);  check_val(d0, 24'h000000);
    reg_read(rpe_pkg::ADDR_IRQEN_A, d0);  check_val(d0, 24'h000000);
    reg_read(rpe_pkg::ADDR_IRQEN_B, d0);  check_val(d0, 24'h000000);
    reg_read(rpe_pkg::ADDR_ENERGY_A, d0); check_val(d0, 24'h000000);
    reg_write(rpe_pkg::ADDR_IRQEN_A, 24'h000003);
    reg_write(rpe_pkg::ADDR_IRQEN_B, 24'h000001);
    reg_write(10'h005, 24'h0000ff);
    reg_read(10'h32c, d0);                check_val(d0, 24'h000003);
    reg_read(10'h32f, d0);                check_val(d0, 24'h000001);
    reg_read(10'h005, d0);                check_val(d0, 24'h000000);
    check_flag(irq, 1'b0);
    // a read strobe while the clock enable is low is ignored
    @(posedge sys_clk);
    clk_en <= 1'b0;
    rd <= 1'b1;
    addr <= rpe_pkg::ADDR_LCYC;
    @(posedge sys_clk);
    rd <= 1'b0;
    seen = 1'b0;
    repeat (3) @(posedge sys_clk) if (rvalid === 1'b1) seen = 1'b1;
    clk_en <= 1'b1;
    check_flag(seen, 1'b0);
    // ia positive, ib negative, v positive
    flag_clear <= 4'hf;
    run_samples(60);
    reg_read(rpe_pkg::ADDR_WATT_A, d0);   check_flag(d0 !== 0 && d0[23] === 1'b0, 1'b1);
    reg_read(10'h312, d1);                check_val(d1, d0);
    reg_write(rpe_pkg::ADDR_WATT_A, 24'h5a5a5a);
    reg_read(rpe_pkg::ADDR_WATT_A, d1);   check_val(d1, d0);
    reg_read(rpe_pkg::ADDR_WATT_B, d0);   check_flag(d0[23], 1'b1);
    reg_read(rpe_pkg::ADDR_ACCUMULATION_MODE_CFG, d0);
    check_flag(d0[rpe_pkg::SIGN_A_BIT], 1'b0);
    check_flag(d0[rpe_pkg::SIGN_B_BIT], 1'b1);
    reg_write(rpe_pkg::ADDR_ACCUMULATION_MODE_CFG, 24'h000000);
    reg_read(rpe_pkg::ADDR_ACCUMULATION_MODE_CFG, d0);  check_flag(d0[rpe_pkg::SIGN_B_BIT], 1'b1);
    reg_read(rpe_pkg::ADDR_IRMS_A, d0);   check_flag(d0 !== 0, 1'b1);
    reg_read(rpe_pkg::ADDR_IRMS_B, d1);   check_val(d1, d0);
    reg_read(10'h31a, d1);                check_val(d1, d0);
    reg_read(10'h31b, d1);                check_val(d1, d0);
    reg_read(rpe_pkg::ADDR_VOLTAGE_RMS_VALUE, d1);     check_val(d1, d0);
    reg_read(10'h31c, d1);                check_val(d1, d0);
    // host reads rms again a whole strobe pair later, in step with the waveform
    repeat (2 * SPACING) @(posedge sys_clk);
    reg_read(rpe_pkg::ADDR_VOLTAGE_RMS_VALUE, d1);     check_val(d1, d0);
    reg_read(rpe_pkg::ADDR_ENERGY_A, d0); check_flag(d0 !== 0 && d0[23] === 1'b0, 1'b1);
    reg_read(10'h31e, d0);                check_val(d0, 24'h000000);
    reg_read(rpe_pkg::ADDR_ENERGY_B, d0); check_flag(d0[23], 1'b1);
    check_val({20'h00000, flags}, 24'h000000);
    flag_clear <= 4'h0;
    // clear-on-read off: energy holds across reads
    reg_write(rpe_pkg::ADDR_LCYC, 24'h000000);
    reg_read(rpe_pkg::ADDR_LCYC, d0);     check_val(d0, 24'h000000);
    run_samples(20);
    reg_read(rpe_pkg::ADDR_ENERGY_A, d1); check_flag(d1 !== 0, 1'b1);
    reg_read(rpe_pkg::ADDR_ENERGY_A, d0); check_val(d0, d1);
    // reverse channel a power: its energy counts down
    ia_lvl <= -24'sh020000;
    ib_lvl <= 24'sh020000;
    run_samples(30);
    reg_read(rpe_pkg::ADDR_ENERGY_A, d2); check_flag($signed(d2) < $signed(d1), 1'b1);
    reg_read(rpe_pkg::ADDR_ACCUMULATION_MODE_CFG, d0);
    check_flag(d0[rpe_pkg::SIGN_A_BIT], 1'b1);
    check_flag(d0[rpe_pkg::SIGN_B_BIT], 1'b0);
    reg_read(rpe_pkg::ADDR_WATT_A, d0);   check_flag(d0[23], 1'b1);
    give_verdict;
  end
endmodule // rpe_core_test
`default_nettype wire
